//--- inc/osm_pkg.sv
// Package of constants and carrier types for the oscillator mode select block.
//
// Operation
// - RC mode: first pin in, second pin quarter-rate
// - RC-with-I/O mode: second pin becomes I/O
// - Configuration field can pick internal oscillators
// - Internal clock-out: pin one I/O, pin two quarter-rate
// - Internal all-I/O mode: both pins are I/O
// - Two independent internal oscillators, each selectable
// - High-frequency oscillator 8 MHz, software tunable
// - Low-frequency oscillator uncalibrated, nominal 31 kHz
// - Three-bit select picks one of eight frequencies
// - High-frequency enable needs nonzero select and request
// - Clock-select bit switches external and internal
// - Readable flag shows high-frequency oscillator stable
// - Select 111 is 8 MHz, halving; 000 low
// - Clock-select 1 internal, 0 configured source
package osm_pkg;

  // Nominal oscillator figures, kept for reference by users of the block.
  localparam int HF_FREQ_HZ = 8000000;
  localparam int LF_FREQ_HZ = 31000;
  localparam int CLK_FREQ_HZ = 25000000;

  // High-frequency oscillator ticks seen before the stable flag rises.
  localparam logic [3:0] HF_STABLE_TICKS = 4'h8;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TUNE = 8'h04;

  // Control register field positions.
  localparam int CTRL_FSEL_LSB = 4;
  localparam int CTRL_OSTS_BIT = 3;
  localparam int CTRL_HTS_BIT = 2;
  localparam int CTRL_LTS_BIT = 1;
  localparam int CTRL_SCS_BIT = 0;
  localparam int TUNE_W = 5;

  // Reset values and fixed select codes.
  localparam logic [2:0] FSEL_RESET = 3'h6;
  localparam logic [2:0] FSEL_LF = 3'h0;
  localparam logic [2:0] FSEL_MAX = 3'h7;
  localparam logic [TUNE_W-1:0] TUNE_RESET = 5'h00;

  // Encoding of the configuration oscillator field.
  localparam logic [2:0] FOSC_RC = 3'h7;
  localparam logic [2:0] FOSC_RESISTOR_CAPACITOR_IO_MODE = 3'h6;
  localparam logic [2:0] FOSC_INT_QUARTER_RATE_CLOCK_OUTPUT = 3'h5;
  localparam logic [2:0] FOSC_INT_IO = 3'h4;

  // Oscillator modes decoded from the configuration word.
  typedef enum logic [2:0] {
    resistor_capacitor_quarter_rate_clock_output_mode,
    resistor_capacitor_io_mode,
    internal_osc_quarter_rate_clock_output_mode,
    internal_osc_all_io_mode,
    external_clock_mode
  } osm_mode_t;

  // One two-way pin as driven by the block.
  typedef struct packed {
    logic out;
    logic oe;
  } osm_pin_t;

  // APB request as seen by the slave.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } osm_apb_req_t;

  // Mask of counter bits that must be all ones for a postscaled tick.
  function automatic logic [5:0] osm_div_mask(input logic [2:0] code);
    osm_div_mask = 6'h3f >> (code - 3'h1);
  endfunction : osm_div_mask

endpackage : osm_pkg

//--- verilog/osm_postscaler.sv
// Binary postscaler that divides the high-frequency oscillator ticks.
`timescale 1ns/10ps
module osm_postscaler (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_hf_tick,
  input  wire logic [2:0] i_code,
  output logic            o_tick
);
  import osm_pkg::*;

  logic [5:0] count;
  wire  [5:0] mask = osm_div_mask(i_code);
  wire        hit = i_hf_tick && ((count & mask) == mask);

  // Free-running tick counter; a ratio change applies from the next source tick, as the mask is not registered.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      count  <= 6'h00;
      o_tick <= 1'b0;
    end else begin
      count  <= i_hf_tick ? count + 6'h01 : count;
      o_tick <= hit && (i_code != FSEL_LF);
    end
  end

endmodule : osm_postscaler

//--- verilog/osm_osc_select.sv
// Oscillator mode select: clock source choice, pin roles and APB registers.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module osm_osc_select (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire osm_pkg::osm_apb_req_t i_apb,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire logic [2:0]           i_cfg_fosc,
  input  wire logic                 i_cfg_two_speed,
  input  wire logic                 i_hf_tick,
  input  wire logic                 i_lf_tick,
  input  wire logic                 i_pin1_in,
  input  wire osm_pkg::osm_pin_t    i_gpio1,
  input  wire osm_pkg::osm_pin_t    i_gpio2,
  output osm_pkg::osm_pin_t         o_pin1,
  output osm_pkg::osm_pin_t         o_pin2,
  output logic                      o_hf_en,
  output logic                      o_lf_en,
  output logic [osm_pkg::TUNE_W-1:0] o_hf_trim,
  output logic                      o_sys_tick
);
  import osm_pkg::*;

  // Configuration capture and software state.
  osm_mode_t   cfg_mode;
  logic        cfg_two_speed;
  logic        cfg_done;
  logic [2:0]  freq_sel;
  logic        system_clock_select;
  logic        high_freq_stable_flag;
  logic        lts;
  logic [3:0]  hf_cnt;
  logic        pin1_last;
  logic [1:0]  quarter_cnt;
  logic        quarter_rate_clock_output;
  logic        post_tick;

  // Configuration field decode, caught once after reset release.
  osm_mode_t next_mode;
  always_comb begin
    case (i_cfg_fosc)
      FOSC_RC:         next_mode = resistor_capacitor_quarter_rate_clock_output_mode;
      FOSC_RESISTOR_CAPACITOR_IO_MODE:       next_mode = resistor_capacitor_io_mode;
      FOSC_INT_QUARTER_RATE_CLOCK_OUTPUT: next_mode = internal_osc_quarter_rate_clock_output_mode;
      FOSC_INT_IO:     next_mode = internal_osc_all_io_mode;
      default:         next_mode = external_clock_mode;
    endcase
  end

  // The configuration word is non-volatile, so it is sampled after reset, never under it.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_mode      <= external_clock_mode;
      cfg_two_speed <= 1'b0;
      cfg_done      <= 1'b0;
    end else if (!cfg_done) begin
      cfg_mode      <= next_mode;
      cfg_two_speed <= i_cfg_two_speed;
      cfg_done      <= 1'b1;
    end
  end

  // Mode classes used by the clock and pin logic.
  wire mode_rc     = (cfg_mode == resistor_capacitor_quarter_rate_clock_output_mode);
  wire mode_resistor_capacitor_io_mode   = (cfg_mode == resistor_capacitor_io_mode);
  wire mode_intck  = (cfg_mode == internal_osc_quarter_rate_clock_output_mode);
  wire mode_intio  = (cfg_mode == internal_osc_all_io_mode);
  wire mode_int    = mode_intck || mode_intio;
  wire pin1_is_ck  = cfg_done && !mode_int;

  // The internal path drives the system clock when selected by software or by configuration.
  wire use_int     = system_clock_select || mode_int;
  wire lf_select   = (freq_sel == FSEL_LF);
  wire next_hf_en  = !lf_select && (use_int || cfg_two_speed);
  wire next_lf_en  = use_int && lf_select;

  // Clock ticks from the first pin, the postscaler and the low-frequency oscillator.
  wire pin1_tick   = pin1_is_ck && i_pin1_in && !pin1_last;
  wire lf_tick     = o_lf_en && i_lf_tick;
  wire hf_tick     = o_hf_en && i_hf_tick;
  wire int_tick    = lf_select ? lf_tick : post_tick;
  wire next_sys    = use_int ? int_tick : pin1_tick;
  wire quarter_rate_clock_output_src  = mode_rc ? pin1_tick : int_tick;

  // Postscaler for the high-frequency oscillator.
  osm_postscaler u_post (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_hf_tick (hf_tick),
    .i_code    (freq_sel),
    .o_tick    (post_tick)
  );

  // Enables, system tick and the edge detector for the first pin.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hf_en    <= 1'b0;
      o_lf_en    <= 1'b0;
      o_sys_tick <= 1'b0;
      pin1_last  <= 1'b0;
    end else begin
      o_hf_en    <= next_hf_en;
      o_lf_en    <= next_lf_en;
      o_sys_tick <= next_sys;
      pin1_last  <= i_pin1_in;
    end
  end

  // Stability: the high-frequency flag rises after a fixed count of ticks.
  // An oscillator that is turned off loses its stable state on the next clock.
  wire hf_done = (hf_cnt == HF_STABLE_TICKS);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hf_cnt <= 4'h0;
      high_freq_stable_flag    <= 1'b0;
      lts    <= 1'b0;
    end else begin
      hf_cnt <= !o_hf_en ? 4'h0 : (hf_tick && !hf_done) ? hf_cnt + 4'h1 : hf_cnt;
      high_freq_stable_flag    <= o_hf_en && hf_done;
      lts    <= o_lf_en && (lts || i_lf_tick);
    end
  end

  // Quarter-rate clock output; two source ticks per half period.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      quarter_cnt <= 2'h0;
      quarter_rate_clock_output      <= 1'b0;
    end else if (quarter_rate_clock_output_src) begin
      quarter_cnt <= quarter_cnt + 2'h1;
      quarter_rate_clock_output      <= (quarter_cnt == 2'h1) ? !quarter_rate_clock_output : (quarter_cnt == 2'h3) ? !quarter_rate_clock_output : quarter_rate_clock_output;
    end
  end

  // Pin role selection for both oscillator pins.
  osm_pin_t next_pin1;
  osm_pin_t next_pin2;
  always_comb begin
    next_pin1 = '{out: 1'b0, oe: 1'b0};
    next_pin2 = '{out: 1'b0, oe: 1'b0};
    if (mode_int) begin
      next_pin1 = i_gpio1;
    end
    if (mode_rc || mode_intck) begin
      next_pin2 = '{out: quarter_rate_clock_output, oe: 1'b1};
    end else if (mode_resistor_capacitor_io_mode || mode_intio) begin
      next_pin2 = i_gpio2;
    end
  end

  // Pins change only after the configuration has been caught.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin1 <= '{out: 1'b0, oe: 1'b0};
      o_pin2 <= '{out: 1'b0, oe: 1'b0};
    end else begin
      o_pin1 <= cfg_done ? next_pin1 : '{out: 1'b0, oe: 1'b0};
      o_pin2 <= cfg_done ? next_pin2 : '{out: 1'b0, oe: 1'b0};
    end
  end

  // APB decode; the ready flop adds one wait state so every answer comes from a register.
  wire access   = i_apb.psel && i_apb.penable && !o_pready;
  wire hit_ctrl = (i_apb.paddr == OFS_CTRL);
  wire hit_tune = (i_apb.paddr == OFS_TUNE);
  wire miss     = !hit_ctrl && !hit_tune;
  wire wr_ctrl  = access && i_apb.pwrite && hit_ctrl;
  wire wr_tune  = access && i_apb.pwrite && hit_tune;
  wire osts     = !use_int;

  // Read data mux; the top bits and unmapped addresses read as zero.
  wire [31:0] rd_ctrl = {25'h0, freq_sel, osts, high_freq_stable_flag, lts, system_clock_select};
  wire [31:0] rd_tune = {{(32-TUNE_W){1'b0}}, o_hf_trim};
  wire [31:0] next_rd = hit_ctrl ? rd_ctrl : hit_tune ? rd_tune : 32'h0;

  // Bus answer and register writes, all at the access edge.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
      freq_sel  <= FSEL_RESET;
      system_clock_select       <= 1'b0;
      o_hf_trim <= TUNE_RESET;
    end else begin
      o_pready  <= access;
      o_pslverr <= access && miss;
      o_prdata  <= (access && !i_apb.pwrite) ? next_rd : 32'h0;
      if (wr_ctrl) begin
        freq_sel <= i_apb.pwdata[CTRL_FSEL_LSB+2:CTRL_FSEL_LSB];
        system_clock_select      <= i_apb.pwdata[CTRL_SCS_BIT];
      end
      if (wr_tune) begin
        o_hf_trim <= i_apb.pwdata[TUNE_W-1:0];
      end
    end
  end

  // Checks of the block's own behaviour.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_hf_off_low: assert property (lf_select && !wr_ctrl |=> !o_hf_en)
    else $error("HF oscillator enabled with select zero");

  a_hf_on_need: assert property (o_hf_en |-> $past(use_int || cfg_two_speed))
    else $error("HF oscillator enabled without a request");

  a_rc_pin_out: assert property (cfg_done && mode_rc |=> o_pin2.oe && !o_pin1.oe)
    else $error("RC mode pin roles wrong");

  a_resistor_capacitor_io_mode_pin_io: assert property (cfg_done && mode_resistor_capacitor_io_mode |=> o_pin2 == $past(i_gpio2))
    else $error("RC I/O mode second pin not I/O");

  a_int_ck_pins: assert property (cfg_done && mode_intck |=> o_pin1 == $past(i_gpio1) && o_pin2.oe)
    else $error("Internal clock-out pin roles wrong");

  a_int_io_pins: assert property (cfg_done && mode_intio |=> o_pin1 == $past(i_gpio1) && o_pin2 == $past(i_gpio2))
    else $error("Internal all-I/O pin roles wrong");

  a_quarter_src: assert property ($changed(quarter_rate_clock_output) |-> $past(quarter_rate_clock_output_src) && $past(quarter_cnt[0]))
    else $error("Quarter-rate output moved off a source tick");

  a_lf_to_sys: assert property (use_int && lf_select && i_lf_tick && o_lf_en |=> o_sys_tick)
    else $error("Low-frequency tick not passed to system clock");

  a_ext_no_int: assert property (!use_int && !pin1_tick |=> !o_sys_tick)
    else $error("System tick without a first-pin edge");

  a_hts_timing: assert property ($rose(high_freq_stable_flag) |-> $past(hf_done) && $past(o_hf_en))
    else $error("Stable flag rose early");

  a_hts_drop: assert property (!o_hf_en |=> !high_freq_stable_flag)
    else $error("Stable flag kept with oscillator off");

  a_post_ratio: assert property (post_tick && $past(freq_sel) == FSEL_MAX |-> $past(hf_tick))
    else $error("Postscaler tick without a source tick");

  a_apb_answer: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("APB answer not one cycle");

  c_rc_quarter_rate_clock_output: cover property (mode_rc ##1 $rose(o_pin2.out));
  c_hts_rise: cover property ($rose(high_freq_stable_flag));
  c_tune_write: cover property (wr_tune);
  c_lf_system: cover property (lf_select && use_int && o_sys_tick);

endmodule : osm_osc_select

//--- sim/osm_osc_model.sv
// Behavioural model of the oscillator macros and the external RC network.
`timescale 1ns/10ps
module osm_osc_model #(
  parameter int HP = 3,
  parameter int LP = 40,
  parameter int RP = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_hf_en,
  input  wire logic i_lf_en,
  output logic      o_hf_tick,
  output logic      o_lf_tick,
  output logic      o_rc_pin
);
  int hc = 0;
  int lc = 0;
  int rc = 0;
  initial o_rc_pin = 1'b0;
  // Both internal oscillators tick only while enabled, so a stuck enable shows as lost ticks; the RC pin always toggles.
  always @(posedge i_ref_clk) begin
    hc <= (hc >= HP - 1) ? 0 : hc + 1;
    lc <= (lc >= LP - 1) ? 0 : lc + 1;
    rc <= (rc >= RP - 1) ? 0 : rc + 1;
    o_hf_tick <= i_hf_en && hc == 0;
    o_lf_tick <= i_lf_en && lc == 0;
    if (rc == 0) o_rc_pin <= ~o_rc_pin;
  end
endmodule : osm_osc_model

//--- sim/tb_top.sv
// Self-checking testbench of the oscillator mode select block.
`timescale 1ns/10ps
module tb_top;
  import osm_pkg::*;
  localparam int HP = 3;
  localparam int LP = 40;
  localparam int RP = 5;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  osm_apb_req_t apb = '0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, err, hf_tick, lf_tick, rc_pin, hf_en, lf_en, sys_tick;
  logic [2:0] fosc = FOSC_RC;
  logic two_sp = 1'b0;
  osm_pin_t gp1 = '0;
  osm_pin_t gp2 = '0;
  osm_pin_t pin1, pin2;
  logic [TUNE_W-1:0] trim;
  logic [31:0] rnd = 32'h0000005a;
  int err_total = 0;
  int num_checks = 0;
  int p;

  // Clock at 25 MHz.
  always #20 i_ref_clk = ~i_ref_clk;

  osm_osc_select dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cfg_fosc(fosc), .i_cfg_two_speed(two_sp),
    .i_hf_tick(hf_tick), .i_lf_tick(lf_tick), .i_pin1_in(rc_pin), .i_gpio1(gp1), .i_gpio2(gp2),
    .o_pin1(pin1), .o_pin2(pin2), .o_hf_en(hf_en), .o_lf_en(lf_en), .o_hf_trim(trim),
    .o_sys_tick(sys_tick));
  osm_osc_model #(.HP(HP), .LP(LP), .RP(RP)) osc (.i_ref_clk(i_ref_clk), .i_hf_en(hf_en),
    .i_lf_en(lf_en), .o_hf_tick(hf_tick), .o_lf_tick(lf_tick), .o_rc_pin(rc_pin));

  // Shift-register generator; the fixed seed keeps every run alike.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Expected system tick period in clocks for a frequency code.
  function automatic int exp_per(input logic [2:0] c);
    return (c == 3'h0) ? LP : HP << (3'h7 - c);
  endfunction : exp_per

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tmo;
    err_total++;
    $display("mismatch wait expected done seen timeout");
    end_sim();
  endtask : tmo

  // Configuration is only captured after reset, so each mode needs a fresh reset.
  task automatic boot(input logic [2:0] f, input logic ts);
    @(posedge i_ref_clk);
    fosc <= f;
    two_sp <= ts;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : boot

  // One APB transfer; pready is read before this edge's updates land.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_ref_clk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    rd = o_prdata;
    err = o_pslverr;
    apb <= '0;
    repeat (3) @(posedge i_ref_clk);
  endtask : xfer

  // Clocks between the second and third system tick, or clock-out rising edge.
  task automatic period(input bit pin, output int pr);
    int n, k, t0;
    logic s, prev;
    k = 0;
    t0 = 0;
    pr = 0;
    prev = 1'b1;
    for (n = 0; n < 3000 && k < 3; n++) begin
      @(posedge i_ref_clk);
      s = pin ? pin2.out : sys_tick;
      if (s && !(pin && prev)) begin
        k++;
        if (k == 2) t0 = n;
        if (k == 3) pr = n - t0;
      end
      prev = s;
    end
    if (k < 3) tmo();
  endtask : period

  // Main sequence.
  initial begin
    boot(FOSC_RC, 1'b0);
    xfer(0, OFS_CTRL, 0);
    chk("ctrl_reset", rd & 32'hf9, 32'h68);
    xfer(0, OFS_TUNE, 0);
    chk("tune_reset", rd, 0);
    xfer(0, 8'h1c, 0);
    chk("bad_err", err, 1);
    chk("bad_data", rd, 0);
    chk("rc_pin1_oe", pin1.oe, 0);
    chk("rc_pin2_oe", pin2.oe, 1);
    chk("rc_hf_off", hf_en, 0);
    period(1, p);
    chk("rc_quarter", p, 8 * RP);
    $display("test external rc done");
    xfer(1, OFS_CTRL, 32'hff);
    xfer(0, OFS_CTRL, 0);
    chk("ctrl_wr", rd & 32'hf1, 32'h71);
    chk("scs_hf_on", hf_en, 1);
    period(0, p);
    chk("hf_tick", p, HP);
    // The stable flag needs eight counted ticks, so give the oscillator time to settle first.
    repeat (40) @(posedge i_ref_clk);
    xfer(0, OFS_CTRL, 0);
    chk("hf_stable", rd[2], 1);
    xfer(1, OFS_CTRL, 32'h01);
    chk("lf_en", {hf_en, lf_en}, 1);
    period(0, p);
    chk("lf_tick", p, LP);
    xfer(0, OFS_CTRL, 0);
    chk("hf_unstable", rd[2], 0);
    rnd = xs(rnd);
    xfer(1, OFS_TUNE, {27'h0, rnd[4:0]});
    chk("trim_out", trim, rnd[4:0]);
    $display("test clock select done");
    boot(FOSC_RC, 1'b1);
    chk("two_speed_hf", hf_en, 1);
    $display("test two speed done");
    for (int f = 4; f < 7; f++) begin
      boot(f[2:0], 1'b0);
      rnd = xs(rnd);
      gp1 <= osm_pin_t'(rnd[1:0]);
      gp2 <= osm_pin_t'(rnd[3:2]);
      repeat (3) @(posedge i_ref_clk);
      if (f != 6) chk("io_pin1", pin1, gp1);
      if (f != 5) chk("io_pin2", pin2, gp2);
      if (f != 6) chk("int_hf_on", hf_en, 1);
      if (f == 5) begin
        period(1, p);
        chk("int_quarter", p, 4 * exp_per(FSEL_RESET));
      end
      $display("test mode %0d done", f);
    end
    for (int c = 7; c >= 0; c--) begin
      xfer(1, OFS_CTRL, {25'h0, c[2:0], 4'h1});
      period(0, p);
      chk("postscale", p, exp_per(c[2:0]));
    end
    $display("test postscaler done");
    end_sim();
  end
endmodule : tb_top
